// [rtl/ssp_clkdiv.sv]
// Purpose: Master serial clock toggle generator
// Assumes: Timer1 match arrives as a one-cycle pulse on clk_sys
// Notes: Emits one pulse per serial clock half period
`timescale 1ns/10ps
module ssp_clkdiv
  import ssp_pkg::*;
#(
  parameter int DIV_W = SSP_DIV_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] mode,
  input wire logic t1_tick,
  // Toggle request
  output logic tgl
);

  logic [DIV_W-1:0] count_r;
  logic [DIV_W-1:0] count_nxt;
  wire [DIV_W-1:0] half_cycles = SSP_HALF_ONE << mode;
  wire count_hit = (count_r == half_cycles - SSP_HALF_ONE);
  wire timer_mode = (mode == MODE_TIMER1);

  // Timer1 output divided by two: each match flips the clock once
  assign tgl = run && (timer_mode ? t1_tick : count_hit);
  assign count_nxt = (!run || tgl) ? '0 : count_r + SSP_HALF_ONE;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

// [rtl/ssp_pkg.sv]
// Purpose: Shared constants and types for the byte-wide serial port
// Assumes: One system clock; control bits arrive as plain levels
// Notes: Mode codes follow the three-bit port mode field
package ssp_pkg;

  localparam int SSP_BITS = 8;
  localparam logic [3:0] SSP_BIT_LAST = 4'h8;
  localparam logic [7:0] SSP_BYTE_RST = 8'h00;

  // Port mode field codes
  localparam logic [2:0] MODE_DIV2 = 3'h0;
  localparam logic [2:0] MODE_DIV32 = 3'h4;
  localparam logic [2:0] MODE_SLV_SS = 3'h5;
  localparam logic [2:0] MODE_SLV_FREE = 3'h6;
  localparam logic [2:0] MODE_TIMER1 = 3'h7;

  // Divider counter width covers the longest half period (16 cycles)
  localparam int SSP_DIV_W = 5;
  localparam logic [SSP_DIV_W-1:0] SSP_HALF_ONE = 5'h01;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } ssp_state_type;

  typedef struct packed {
    logic port_enable;
    logic clock_edge_select;
    logic [2:0] port_mode_field;
  } ssp_ctrl_type;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
  } ssp_pin_out_type;

endpackage

// [rtl/ssp_port.sv]
// Purpose: Byte-wide master/slave synchronous serial port
// Assumes: Software side drives plain levels and one-cycle pulses
// Notes: Pin inputs pass two flip-flops; fastest master rate limits sdi
`timescale 1ns/10ps
module ssp_port
  import ssp_pkg::*;
#(
  parameter int BITS = SSP_BITS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration levels
  input wire ssp_ctrl_type ctrl,
  input wire logic serial_irq_enable,
  // Software strobes
  input wire logic shift_enable_set,
  input wire logic tx_wr,
  input wire logic [BITS-1:0] tx_data,
  input wire logic rx_rd,
  input wire logic receive_buffer_full_clr,
  input wire logic irq_flag_clr,
  // Timer1 period match pulse
  input wire logic t1_tick,
  // Status
  output logic shift_enable,
  output logic [BITS-1:0] receive_buffer,
  output logic receive_buffer_full,
  output logic serial_irq_flag,
  output logic serial_irq_req,
  // Serial pins
  input wire logic sck_in,
  input wire logic sdi,
  input wire logic slave_select_n,
  output ssp_pin_out_type pins
);

  ssp_state_type state_r, state_nxt;
  logic [BITS-1:0] transmit_buffer_r;
  logic [BITS-1:0] serial_shift_register_r;
  logic [BITS-1:0] receive_buffer_r;
  logic [3:0] bit_cnt_r;
  logic samp_r, pend_r, sck_r, full_r, flag_r;
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2, ss_s1, ss_s2;
  logic div_tgl;

  // Mode decode
  wire [2:0] mode = ctrl.port_mode_field;
  wire slave = (mode == MODE_SLV_SS) || (mode == MODE_SLV_FREE);
  wire master = !slave;
  wire ss_gate = (mode == MODE_SLV_SS);
  wire ss_active = !ss_gate || !ss_s2;
  wire idle_lvl = !ctrl.clock_edge_select;
  wire busy = (state_r == ST_SHIFT);

  // Start and edge qualification
  wire start = shift_enable_set && ctrl.port_enable && !busy;
  wire sck_rise = sck_s2 && !sck_s3;
  wire sck_fall = !sck_s2 && sck_s3;
  wire slv_samp = ctrl.clock_edge_select ? sck_rise : sck_fall;
  wire slv_shift = ctrl.clock_edge_select ? sck_fall : sck_rise;
  wire mst_samp = div_tgl && (sck_r == idle_lvl);
  wire mst_shift = div_tgl && (sck_r != idle_lvl);
  // Edges only count while a byte is armed
  wire samp_edge = busy && (master ? mst_samp : (slv_samp && ss_active));
  wire shift_edge = busy && pend_r && (master ? mst_shift : (slv_shift && ss_active));
  wire done = shift_edge && (bit_cnt_r == SSP_BIT_LAST);
  wire [BITS-1:0] shifted = {serial_shift_register_r[BITS-2:0], samp_r};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (done || !ctrl.port_enable) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Two-stage synchronisers; a third sck stage (sck_s3) also feeds edge detection
  always_ff @(posedge clk_sys) begin
    sck_s1 <= sck_in;
    sck_s2 <= sck_s1;
    sck_s3 <= sck_s2;
    sdi_s1 <= sdi;
    sdi_s2 <= sdi_s1;
    ss_s1 <= slave_select_n;
    ss_s2 <= ss_s1;
  end

  ssp_clkdiv #(.DIV_W(SSP_DIV_W)) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(busy && master),
    .mode(mode),
    .t1_tick(t1_tick),
    .tgl(div_tgl)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      sck_r <= 1'b1;
      bit_cnt_r <= '0;
      samp_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Master clock parks at idle level between bytes
      sck_r <= (busy && master && div_tgl) ? !sck_r : (busy ? sck_r : idle_lvl);
      bit_cnt_r <= start ? '0 : (samp_edge ? bit_cnt_r + 4'h1 : bit_cnt_r);
      samp_r <= samp_edge ? sdi_s2 : samp_r;
      pend_r <= start ? 1'b0 : (samp_edge ? 1'b1 : (shift_edge ? 1'b0 : pend_r));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      transmit_buffer_r <= SSP_BYTE_RST;
      serial_shift_register_r <= SSP_BYTE_RST;
      receive_buffer_r <= SSP_BYTE_RST;
    end else begin
      transmit_buffer_r <= tx_wr ? tx_data : transmit_buffer_r;
      // Load at arming so the MSB is on sdo before the first edge
      if (start) begin
        serial_shift_register_r <= transmit_buffer_r;
      end else if (shift_edge) begin
        serial_shift_register_r <= shifted;
      end
      receive_buffer_r <= done ? shifted : receive_buffer_r;
    end
  end

  // Set beats clear on both flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      full_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      full_r <= done || (full_r && !rx_rd && !receive_buffer_full_clr);
      flag_r <= done || (flag_r && !irq_flag_clr);
    end
  end

  assign shift_enable = busy;
  assign receive_buffer = receive_buffer_r;
  assign receive_buffer_full = full_r;
  assign serial_irq_flag = flag_r;
  assign serial_irq_req = flag_r && serial_irq_enable;
  // One driver for the whole pin struct keeps the output a single continuous assignment
  assign pins = '{
    sck_out: sck_r,
    sck_oe: ctrl.port_enable && master,
    sdo: serial_shift_register_r[BITS-1],
    sdo_oe: ctrl.port_enable && ss_active
  };

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end;
    done ##1 !shift_enable;
  endsequence

  a_done_sets_full: assert property (done |=> receive_buffer_full && serial_irq_flag)
    else $error("Completion did not set full and irq flag");
  a_done_drops_enable: assert property (done |-> s_byte_end)
    else $error("Shift enable still set after byte end");
  a_busy_holds: assert property (busy && !done && ctrl.port_enable |=> shift_enable)
    else $error("Shift enable dropped mid byte");
  a_start_loads: assert property (start |=> pins.sdo == $past(transmit_buffer_r[BITS-1]))
    else $error("Transmit buffer not loaded at start");
  a_flag_sticky: assert property (serial_irq_flag && !irq_flag_clr |=> serial_irq_flag)
    else $error("Irq flag cleared without software");
  a_read_clears: assert property (rx_rd && !done |=> !receive_buffer_full)
    else $error("Receive read did not clear full bit");
  a_req_masked: assert property (!serial_irq_enable |-> !serial_irq_req)
    else $error("Irq request with enable clear");
  a_select_floats: assert property (ss_gate && ss_s2 |-> !pins.sdo_oe)
    else $error("Output driven while deselected");
  a_slave_sck_in: assert property (slave |-> !pins.sck_oe)
    else $error("Slave drives the serial clock");
  a_idle_stable: assert property (!busy && !start |=> $stable(serial_shift_register_r)
    && $stable(receive_buffer_r))
    else $error("Registers moved while idle");
  a_rx_msb_first: assert property (done |=> receive_buffer[0] == $past(samp_r))
    else $error("Last bit not in LSB");
  a_clock_parks: assert property (!busy |=> pins.sck_out == $past(idle_lvl))
    else $error("Serial clock not parked at idle level");

endmodule

// [tb/ssp_far_end.sv]
// Purpose: Far-end serial peer for the port bench
// Assumes: Acts as slave on the device clock, or as master with its own clock
// Notes: Outside a frame sdi shows the inverse of its MSB, so stale data cannot pass
`timescale 1ns/10ps
module ssp_far_end (
  // Clock and pins
  input wire logic clk_sys,
  input wire logic sck,
  input wire logic sdo,
  input wire logic edge_sel,
  output logic sck_gen,
  output logic sdi
);
  logic [7:0] sr = 8'h00;
  logic [7:0] rx = 8'h00;
  logic live = 1'b0;
  initial sck_gen = 1'b1;
  assign sdi = live ? sr[7] : ~sr[7];
  // Sample on one edge, shift on the other, MSB first
  always @(sck) begin
    if (live && sck === edge_sel) rx = {rx[6:0], sdo};
    else if (live && sck === ~edge_sel) sr = {sr[6:0], sr[7]};
  end
  // Slave-mode clock; half period kept well above the pin sync delay
  task automatic clock_byte();
    live = 1'b1;
    repeat (16) begin
      repeat (6) @(posedge clk_sys);
      sck_gen <= ~sck_gen;
    end
    repeat (6) @(posedge clk_sys);
    live = 1'b0;
  endtask
endmodule

// [tb/ssp_port_tb.sv]
// Purpose: Self-checking bench for the byte-wide serial port
// Assumes: Far-end peer answers as slave or drives the clock as master
// Notes: At Fosc/2 and Fosc/4 the peer byte is all ones or zeros; sdi sync lags two cycles
`timescale 1ns/10ps
module ssp_port_tb
  import ssp_pkg::*;
;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  ssp_ctrl_type ctrl = '0;
  logic [4:0] stb = 5'h00;
  logic [7:0] tx_data = 8'h00;
  logic irq_en = 1'b0;
  logic ssn = 1'b1;
  logic t1_tick = 1'b0;
  logic [1:0] tc = 2'h0;
  logic busy, full, flag, req, sck_w, sck_gen, sdi;
  logic [7:0] rb;
  ssp_pin_out_type pins;
  int err_count = 0;
  int n_compared = 0;

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tc <= tc + 2'h1;
    t1_tick <= (tc == 2'h3);
  end
  assign sck_w = pins.sck_oe ? pins.sck_out : sck_gen;

  ssp_port ssp_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl),
    .serial_irq_enable(irq_en), .shift_enable_set(stb[0]), .tx_wr(stb[1]),
    .tx_data(tx_data), .rx_rd(stb[2]), .receive_buffer_full_clr(stb[3]), .irq_flag_clr(stb[4]),
    .t1_tick(t1_tick), .shift_enable(busy), .receive_buffer(rb),
    .receive_buffer_full(full), .serial_irq_flag(flag), .serial_irq_req(req),
    .sck_in(sck_w), .sdi(sdi), .slave_select_n(ssn), .pins(pins));
  ssp_far_end ssp_far_end_inst (.clk_sys(clk_sys), .sck(sck_w), .sdo(pins.sdo),
    .edge_sel(ctrl.clock_edge_select), .sck_gen(sck_gen), .sdi(sdi));

  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    stb <= 5'h01 << i;
    @(posedge clk_sys);
    stb <= 5'h00;
    #1;
  endtask

  task automatic cfg(input logic [2:0] m, input logic es);
    @(posedge clk_sys);
    ctrl <= '{1'b1, es, m};
    ssp_far_end_inst.sck_gen <= ~es;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 3000) begin
        err_count++;
        tally_and_finish();
      end
    end
  endtask

  // One byte each way; the unread previous byte is simply overwritten
  task automatic xfer(input logic [2:0] m, input logic es, input logic [7:0] bd, bf);
    logic slv;
    int cyc;
    slv = (m == MODE_SLV_SS) || (m == MODE_SLV_FREE);
    cfg(m, es);
    ssp_far_end_inst.sr = bf;
    if (!slv) ssp_far_end_inst.live = 1'b1;
    @(posedge clk_sys);
    tx_data <= bd;
    stb <= 5'h02;
    @(posedge clk_sys);
    stb <= 5'h01;
    @(posedge clk_sys);
    stb <= 5'h00;
    #1;
    `CHK(busy, 1'b1)
    `CHK(pins.sck_oe, ~slv)
    if (slv) ssp_far_end_inst.clock_byte();
    wait_idle(cyc);
    ssp_far_end_inst.live = 1'b0;
    if (m <= MODE_DIV32) `CHK(cyc, (32'd16 << m))
    `CHK(rb, bf)
    `CHK(ssp_far_end_inst.rx, bd)
    `CHK({full, flag}, 2'h3)
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({busy, rb, full, flag, req, pins.sdo}, 13'h0000)
    pulse(0);
    #8;
    `CHK(busy, 1'b0)
    for (int i = 0; i < 4; i++) begin
      xfer((i == 3) ? MODE_TIMER1 : 3'(i + 2), i[0], 8'ha5 + 8'(i), 8'h3c ^ 8'(i));
    end
    xfer(MODE_DIV2, 1'b0, 8'h5a, 8'hff);
    xfer(MODE_DIV2 + 3'h1, 1'b1, 8'hc3, 8'h00);
    cfg(MODE_SLV_SS, 1'b0);
    `CHK(pins.sdo_oe, 1'b0)
    @(posedge clk_sys);
    ssn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(pins.sdo_oe, 1'b1)
    xfer(MODE_SLV_SS, 1'b1, 8'h81, 8'h7e);
    @(posedge clk_sys);
    ssn <= 1'b1;
    xfer(MODE_SLV_FREE, 1'b0, 8'h4b, 8'hd2);
    `CHK(req, 1'b0)
    @(posedge clk_sys);
    irq_en <= 1'b1;
    pulse(2);
    `CHK({full, flag, req}, 3'h3)
    ssp_far_end_inst.clock_byte();
    `CHK({rb, full}, 9'h1a4)
    xfer(MODE_SLV_FREE, 1'b1, 8'h11, 8'he7);
    pulse(3);
    `CHK(full, 1'b0)
    pulse(4);
    `CHK({flag, req}, 2'h0)
    tally_and_finish();
  end
endmodule
